// File: core/csd_config_decode.v
// Clock synth configuration decoder with APB access to the stored settings
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "csd_regs.vh"
module csd_config_decode #(
  parameter RW = 32
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Mode pins and loop state
  input wire [1:0] mode_pins,
  input wire third_mode_pin,
  input wire auto_switch_en,
  input wire sync_clk_present,
  input wire pll_locked,
  input wire dynamic_ratio_valid,
  // Decoded controls
  output reg fractional_source_select,
  output reg [4:0] ratio_frac_bits,
  output reg [RW-1:0] effective_ratio,
  output reg [2:0] reference_divider,
  output reg reference_divider_valid,
  output reg [7:0] min_loop_bandwidth_hz,
  output reg [1:0] auxiliary_source_select,
  output reg ratio_shift_enable,
  output reg [1:0] ratio_shift_select,
  output reg main_out_enable,
  output reg main_out_force_low,
  output reg aux_out_enable,
  // Auxiliary pin as lock indicator
  output reg aux_lock_active,
  output reg aux_lock_out,
  output reg aux_lock_oe_n
);
  localparam MW = 7;
  localparam GW = 11;
  reg [GW-1:0] global_cfg;
  reg [MW-1:0] modal_cfg [0:3];
  reg [RW-1:0] user_ratio_word [0:3];
  reg programmed;
  wire [4*MW-1:0] modal_flat;
  wire [4*RW-1:0] ratio_flat;
  wire [MW-1:0] modal_sel;
  wire [RW-1:0] ratio_sel;
  wire wr_en;
  wire rd_en;
  wire [2:0] third_pin_function;
  wire ratio_format_select;
  wire output_on_unlock;
  wire [1:0] reference_divider_select;
  wire lock_indicator_driver_cfg;
  wire [2:0] min_loop_bandwidth;
  reg next_frac;
  reg [1:0] next_aux;
  reg next_main_en;
  reg next_aux_en;
  reg [2:0] next_div;
  reg next_div_ok;
  reg auto_manual;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & (paddr > `CSD_ADDR_CTRL1);
  assign third_pin_function = global_cfg[`CSD_GLB_P2_LSB +: 3];
  assign ratio_format_select = global_cfg[`CSD_GLB_FMT_BIT];
  assign output_on_unlock = global_cfg[`CSD_GLB_UNL_BIT];
  assign reference_divider_select = global_cfg[`CSD_GLB_DIV_LSB +: 2];
  assign lock_indicator_driver_cfg = global_cfg[`CSD_GLB_LOCKDRV_BIT];
  assign min_loop_bandwidth = global_cfg[`CSD_GLB_BW_LSB +: 3];

  // Storage is one-time: writes land only until a 1 is written to bit 0 of the lock word
  integer i;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_cfg <= `CSD_GLB_RESET;
      programmed <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
        modal_cfg[i] <= `CSD_MOD_RESET;
        user_ratio_word[i] <= `CSD_RATIO_RESET;
      end
    end
    else if (wr_en && !programmed)
    begin
      if (paddr == `CSD_ADDR_GLOBAL)
        global_cfg <= pwdata[GW-1:0];
      if (paddr == `CSD_ADDR_LOCKED)
        programmed <= pwdata[0];
      for (i = 0; i < 4; i = i + 1)
      begin
        if (paddr == `CSD_ADDR_MODAL0 + 12'h004 * i[11:0])
          modal_cfg[i] <= pwdata[MW-1:0];
        if (paddr == `CSD_ADDR_RATIO0 + 12'h004 * i[11:0])
          user_ratio_word[i] <= pwdata[RW-1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_flat
      assign modal_flat[g*MW +: MW] = modal_cfg[g];
      assign ratio_flat[g*RW +: RW] = user_ratio_word[g];
    end
  endgenerate

  csd_modal_mux #(
    .MW(MW),
    .RW(RW)
  ) u_mux (
    .modal_sets(modal_flat),
    .ratio_sets(ratio_flat),
    .set_index(mode_pins),
    .modal_sel(modal_sel),
    .ratio_sel(ratio_sel)
  );

  // Decode of source, aux route, output enables and divider
  always @*
  begin
    auto_manual = (third_pin_function == `CSD_P2_FORCE_MAN) && third_mode_pin;
    if (auto_switch_en && !auto_manual)
      next_frac = sync_clk_present & dynamic_ratio_valid;
    else if (third_pin_function == `CSD_P2_FRAC_OVR && !auto_switch_en)
      next_frac = third_mode_pin;
    else
      next_frac = modal_sel[`CSD_MOD_FRAC_BIT];
    if (third_pin_function == `CSD_P2_AUX_FORCE && third_mode_pin)
      next_aux = `CSD_AUX_MAIN;
    else
      next_aux = modal_sel[`CSD_MOD_AUX_LSB +: 2];
    // Pin high disables; 101 falls to default so no output is touched
    next_main_en = 1'b1;
    next_aux_en = 1'b1;
    case (third_pin_function)
      `CSD_P2_DIS_MAIN: next_main_en = ~third_mode_pin;
      `CSD_P2_DIS_AUX: next_aux_en = ~third_mode_pin;
      `CSD_P2_DIS_BOTH:
      begin
        next_main_en = ~third_mode_pin;
        next_aux_en = ~third_mode_pin;
      end
      default: next_main_en = 1'b1;
    endcase
    // Reserved divider code keeps divide by 4, the safest for fast refs
    case (reference_divider_select)
      `CSD_DIV_4: next_div = 3'h4;
      `CSD_DIV_2: next_div = 3'h2;
      `CSD_DIV_1: next_div = 3'h1;
      default: next_div = 3'h4;
    endcase
    next_div_ok = (reference_divider_select != 2'h3);
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fractional_source_select <= 1'b0;
      ratio_frac_bits <= `CSD_FRAC_BITS_ACC;
      effective_ratio <= `CSD_RATIO_RESET;
      reference_divider <= 3'h4;
      reference_divider_valid <= 1'b1;
      min_loop_bandwidth_hz <= 8'h01;
      auxiliary_source_select <= `CSD_AUX_REF;
      ratio_shift_enable <= 1'b0;
      ratio_shift_select <= 2'h0;
      main_out_enable <= 1'b0;
      main_out_force_low <= 1'b1;
      aux_out_enable <= 1'b0;
      aux_lock_active <= 1'b0;
      aux_lock_out <= 1'b1;
      aux_lock_oe_n <= 1'b1;
    end
    else
    begin
      fractional_source_select <= next_frac;
      if (next_frac && !ratio_format_select)
        ratio_frac_bits <= `CSD_FRAC_BITS_HIGH;
      else
        ratio_frac_bits <= `CSD_FRAC_BITS_ACC;
      effective_ratio <= ratio_sel;
      reference_divider <= next_div;
      reference_divider_valid <= next_div_ok;
      min_loop_bandwidth_hz <= 8'h01 << min_loop_bandwidth;
      auxiliary_source_select <= next_aux;
      ratio_shift_enable <= (third_pin_function == `CSD_P2_SHIFT_EN) && third_mode_pin;
      ratio_shift_select <= modal_sel[`CSD_MOD_SHIFT_LSB +: 2];
      main_out_enable <= next_main_en;
      main_out_force_low <= ~output_on_unlock & ~pll_locked;
      aux_out_enable <= next_aux_en;
      aux_lock_active <= (next_aux == `CSD_AUX_LOCK);
      if (next_aux != `CSD_AUX_LOCK)
      begin
        aux_lock_out <= 1'b0;
        aux_lock_oe_n <= 1'b1;
      end
      else if (!lock_indicator_driver_cfg)
      begin
        aux_lock_out <= ~pll_locked;
        aux_lock_oe_n <= ~next_aux_en;
      end
      else
      begin
        aux_lock_out <= 1'b0;
        aux_lock_oe_n <= pll_locked | ~next_aux_en;
      end
    end
  end

  // Read data registered in setup so it is valid through access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      prdata <= 32'h00000000;
      case (paddr)
        `CSD_ADDR_GLOBAL: prdata <= {21'h000000, global_cfg};
        `CSD_ADDR_LOCKED: prdata <= {31'h00000000, programmed};
        `CSD_ADDR_STATUS: prdata <= {20'h00000, reference_divider_valid, reference_divider,
          ratio_frac_bits, fractional_source_select, auxiliary_source_select};
        `CSD_ADDR_CTRL0: prdata <= {24'h000000, min_loop_bandwidth_hz};
        `CSD_ADDR_CTRL1: prdata <= {26'h0000000, ratio_shift_enable, ratio_shift_select,
          main_out_enable, main_out_force_low, aux_out_enable};
        default:
        begin
          for (i = 0; i < 4; i = i + 1)
          begin
            if (paddr == `CSD_ADDR_MODAL0 + 12'h004 * i[11:0])
              prdata <= {25'h0000000, modal_cfg[i]};
            if (paddr == `CSD_ADDR_RATIO0 + 12'h004 * i[11:0])
              prdata <= user_ratio_word[i];
          end
        end
      endcase
    end
  end
endmodule // csd_config_decode

// File: core/csd_regs.vh
// Register map, field codes and reset values of the clock synth configuration decoder
`ifndef CSD_REGS_VH
`define CSD_REGS_VH
`define CSD_ADDR_GLOBAL 12'h000
`define CSD_ADDR_MODAL0 12'h004
`define CSD_ADDR_RATIO0 12'h014
`define CSD_ADDR_LOCKED 12'h024
`define CSD_ADDR_STATUS 12'h028
`define CSD_ADDR_CTRL0 12'h02C
`define CSD_ADDR_CTRL1 12'h030
`define CSD_GLB_BW_LSB 0
`define CSD_GLB_P2_LSB 3
`define CSD_GLB_FMT_BIT 6
`define CSD_GLB_UNL_BIT 7
`define CSD_GLB_DIV_LSB 8
`define CSD_GLB_LOCKDRV_BIT 10
`define CSD_GLB_RESET 11'h000
`define CSD_MOD_FRAC_BIT 0
`define CSD_MOD_RIDX_LSB 1
`define CSD_MOD_AUX_LSB 3
`define CSD_MOD_SHIFT_LSB 5
`define CSD_MOD_RESET 7'h00
`define CSD_RATIO_RESET 32'h00000000
`define CSD_AUX_REF 2'h0
`define CSD_AUX_SYNC 2'h1
`define CSD_AUX_MAIN 2'h2
`define CSD_AUX_LOCK 2'h3
`define CSD_DIV_4 2'h0
`define CSD_DIV_2 2'h1
`define CSD_DIV_1 2'h2
`define CSD_P2_DIS_MAIN 3'h0
`define CSD_P2_DIS_AUX 3'h1
`define CSD_P2_DIS_BOTH 3'h2
`define CSD_P2_SHIFT_EN 3'h3
`define CSD_P2_FORCE_MAN 3'h4
`define CSD_P2_FRAC_OVR 3'h6
`define CSD_P2_AUX_FORCE 3'h7
`define CSD_FRAC_BITS_HIGH 5'h0C
`define CSD_FRAC_BITS_ACC 5'h14
`endif

// File: core/csd_modal_mux.v
// Selector of one of four modal configuration sets and its ratio word
`timescale 1ns/1ps
module csd_modal_mux #(
  parameter MW = 7,
  parameter RW = 32
) (
  // Stored sets, packed set 0 lowest
  input wire [4*MW-1:0] modal_sets,
  input wire [4*RW-1:0] ratio_sets,
  // Index
  input wire [1:0] set_index,
  // Selected outputs
  output wire [MW-1:0] modal_sel,
  output wire [RW-1:0] ratio_sel
);
  assign modal_sel = modal_sets[set_index*MW +: MW];
  assign ratio_sel = ratio_sets[set_index*RW +: RW];
endmodule // csd_modal_mux

// File: tb/csd_config_checker.sv
// Port assertions for the clock synth configuration decoder
`timescale 1ns/1ps
module csd_config_checker (
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  // Pins and controls
  input wire third_mode_pin,
  input wire pll_locked,
  input wire fractional_source_select,
  input wire [4:0] ratio_frac_bits,
  input wire main_out_enable,
  input wire main_out_force_low,
  input wire aux_out_enable,
  input wire aux_lock_active,
  input wire aux_lock_out,
  input wire aux_lock_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Locked, then lock pin driving
  sequence s_drv;
    pll_locked ##1 (aux_lock_active && !aux_lock_oe_n);
  endsequence
  a_bus_unmapped: assert property (
    psel && penable |-> pslverr == (paddr > 12'h030)) else $error("bad slave error");
  a_read_hold: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
  a_static_fmt: assert property (
    !fractional_source_select |-> ratio_frac_bits == 5'h14) else $error("static format");
  a_frac_width: assert property (
    ratio_frac_bits inside {5'h0C, 5'h14}) else $error("fraction width");
  a_locked_on: assert property (
    pll_locked |=> !main_out_force_low) else $error("forced low while locked");
  a_pin_low: assert property (
    !third_mode_pin |=> main_out_enable && aux_out_enable) else $error("disabled, pin low");
  a_lock_quiet: assert property (
    s_drv |-> !aux_lock_out) else $error("unlock shown while locked");
  a_lock_free: assert property (
    !aux_lock_active |-> aux_lock_oe_n) else $error("lock pin driven");
endmodule // csd_config_checker

bind csd_config_decode csd_config_checker i_csd_config_checker (.*);

// File: tb/tb_top.sv
// Self-checking bench for the clock synth configuration decoder
`timescale 1ns/1ps
`include "csd_regs.vh"
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic third_mode_pin = 1'b0, pll_locked = 1'b0, auto_switch_en = 1'b0;
  logic sync_clk_present = 1'b1, dynamic_ratio_valid = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [1:0] mode_pins = 2'h0;
  wire pready, pslverr, fractional_source_select, reference_divider_valid, ratio_shift_enable;
  wire main_out_enable, main_out_force_low, aux_out_enable, aux_lock_active, aux_lock_out;
  wire aux_lock_oe_n;
  wire [31:0] prdata, effective_ratio;
  wire [4:0] ratio_frac_bits;
  wire [2:0] reference_divider;
  wire [7:0] min_loop_bandwidth_hz;
  wire [1:0] auxiliary_source_select, ratio_shift_select;
  integer num_errors = 0, total_checks = 0, i, p;
  logic [31:0] rv [4] = '{32'h0013A92A, 32'h10000000,
    32'h32000000, 32'h2DF5E208};
  csd_config_decode i_csd_config_decode (.*);
  initial forever #4 pclk = ~pclk;
  task ck(input logic [31:0] s, input logic [31:0] e);
    total_checks = total_checks + 1;
    if (s !== e)
    begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Request held until pready is seen high
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n = n + 1;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    num_errors = num_errors + (n == 20);
    if (n == 20)
      complete_run;
  endtask
  // Outputs lag a change by one edge; three leave margin
  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task cfg(input logic [31:0] g, input logic [31:0] m);
    bus(1'b1, `CSD_ADDR_GLOBAL, g);
    bus(1'b1, `CSD_ADDR_MODAL0, m);
    settle;
  endtask
  task t_ratio;
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, `CSD_ADDR_RATIO0 + 12'(4 * i), rv[i]);
      mode_pins <= 2'(i);
      settle;
      ck(effective_ratio, rv[i]);
    end
    mode_pins <= 2'h0;
    bus(1'b0, 12'h034, 32'h0);
    ck(err, 1'b1);
    ck(rd, 32'h0);
  endtask
  task t_source;
    for (i = 0; i < 4; i++)
    begin
      cfg((i / 2) << 6, i % 2);
      ck(fractional_source_select, i % 2);
      ck(ratio_frac_bits, (i == 1) ? 12 : 20);
    end
    cfg(6 << 3, 0);
    third_mode_pin <= 1'b1;
    settle;
    ck(fractional_source_select, 1'b1);
    cfg(4 << 3, 0);
    auto_switch_en <= 1'b1;
    settle;
    ck(fractional_source_select, 1'b0);
    third_mode_pin <= 1'b0;
    settle;
    ck(ratio_frac_bits, 12);
    sync_clk_present <= 1'b0;
    settle;
    ck(ratio_frac_bits, 20);
    auto_switch_en <= 1'b0;
  endtask
  task t_pins;
    for (i = 0; i < 16; i++)
    begin
      p = i % 8;
      cfg(p | (p << 3) | ((p % 4) << 8), 32'h20);
      third_mode_pin <= 1'(i / 8);
      settle;
      ck(min_loop_bandwidth_hz, 1 << p);
      ck(reference_divider, (p % 4 == 3) ? 4 : 4 >> (p % 4));
      ck(reference_divider_valid, p % 4 != 3);
      ck(main_out_enable, !(i > 7 && (p == 0 || p == 2)));
      ck(aux_out_enable, !(i > 7 && (p == 1 || p == 2)));
      ck(ratio_shift_enable, i > 7 && p == 3);
      ck(auxiliary_source_select, (i > 7 && p == 7) ? 2 : 0);
    end
    ck(ratio_shift_select, 1);
    third_mode_pin <= 1'b0;
  endtask
  task t_lock;
    for (i = 0; i < 8; i++)
    begin
      p = (i / 2) % 2;
      cfg(((i % 2) << 10) | ((i / 4) << 7), 32'h18);
      pll_locked <= 1'(p);
      settle;
      ck(auxiliary_source_select, 3);
      ck(aux_lock_active, 1'b1);
      ck(aux_lock_out, (i % 2) ? 0 : !p);
      ck(aux_lock_oe_n, (i % 2) ? p : 0);
      ck(main_out_force_low, i < 4 && !p);
    end
    cfg(32'h400, 32'h8);
    ck(auxiliary_source_select, 1);
    ck(aux_lock_oe_n, 1'b1);
    ck(aux_lock_active, 1'b0);
  endtask
  // Read back, then lock storage; later writes must not land
  task t_store;
    bus(1'b0, `CSD_ADDR_RATIO0 + 12'h00C, 32'h0);
    ck(rd, rv[3]);
    ck(pready, 1'b1);
    bus(1'b1, `CSD_ADDR_LOCKED, 32'h1);
    bus(1'b1, `CSD_ADDR_RATIO0, 32'h0);
    mode_pins <= 2'h0;
    settle;
    ck(effective_ratio, rv[0]);
    bus(1'b0, `CSD_ADDR_LOCKED, 32'h0);
    ck(rd, 32'h1);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_ratio;
    t_source;
    t_pins;
    t_lock;
    t_store;
    complete_run;
  end
endmodule // tb_top
